// ==== bench/rls_master_model.sv ====
`timescale 1ns/1ps
// serial master: one request at a time, line left idle-high between frames
module rls_master_model (
    input wire logic ref_clk,
    input wire logic reply_grant,
    output logic serial_rx,
    output logic frame_valid,
    output logic [7:0] frame_station,
    output logic [7:0] frame_function
);
    initial
    begin
        serial_rx = 1'b1;
        frame_valid = 1'b0;
        frame_station = 8'h00;
        frame_function = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic send_frame(input logic [7:0] st, input logic [7:0] fn, output logic got);
        got = 1'b0;
        // start and data bits toggle the pair; half duplex, no parity
        repeat (8)
        begin
            @(posedge ref_clk);
            serial_rx <= ~serial_rx;
        end
        @(posedge ref_clk);
        frame_valid <= 1'b1;
        frame_station <= st;
        frame_function <= fn;
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        // stale fields would hide a decode that ignores valid
        frame_station <= ~st;
        frame_function <= ~fn;
        repeat (2)
        begin
            @(negedge ref_clk);
            got = got | (reply_grant === 1'b1);
        end
    endtask
endmodule // rls_master_model

// ==== bench/rls_supervisor_test.sv ====
`timescale 1ns/1ps
module rls_supervisor_test;
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, tx_request = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [9:0] v_in = 10'h1f4, c_in = 10'h1f4;
    logic [15:0] freq_ref_in = 16'h1234, baud_div, freq_cmd;
    logic avs_waitrequest, serial_rx, frame_valid, reply_grant, line_drive_en, cut, decel;
    logic oe_n, relay, g, od_out;
    logic [7:0] frame_station, frame_function;
    logic [1:0] stop_bits;
    logic [3:0] data_bits;
    logic [15:0] divs [5] = '{16'h208d, 16'h1046, 16'h0823, 16'h0411, 16'h0208};
    int fail_count = 0, total_checks = 0;
    always #50 ref_clk = ~ref_clk;
    // short tenth-second so waits stay in tens of cycles
    rls_supervisor #(.TENTH_CYCLES(10)) uut (.ref_clk(ref_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .voltage_analog_input(v_in),
        .current_analog_input(c_in), .freq_ref_in(freq_ref_in), .serial_rx(serial_rx),
        .frame_valid(frame_valid), .frame_station(frame_station),
        .frame_function(frame_function), .tx_request(tx_request), .reply_grant(reply_grant),
        .line_drive_en(line_drive_en), .baud_div(baud_div), .stop_bits(stop_bits),
        .data_bits(data_bits), .freq_cmd(freq_cmd), .output_cut(cut), .decel_req(decel),
        .open_drain_output_out(od_out), .open_drain_output_oe_n(oe_n),
        .fault_relay_output(relay));
    rls_master_model plc (.ref_clk(ref_clk), .reply_grant(reply_grant), .serial_rx(serial_rx),
        .frame_valid(frame_valid), .frame_station(frame_station),
        .frame_function(frame_function));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest and readdata seen as they stood before this edge
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(rls_pkg::OFS_WAIT, 32'h00a);
        rd(rls_pkg::OFS_SERIAL, 32'h0301);
        rd(rls_pkg::OFS_COMM_TO, 32'h00a);
        rd(rls_pkg::OFS_OUTFN, 32'h110c);
        rd(rls_pkg::OFS_FREQ, 32'h1234);
        rd(6'h24, 32'h0);
        chk(data_bits, 4'h8);
        bus(1'b1, rls_pkg::OFS_WAIT, 32'h0);
        rd(rls_pkg::OFS_WAIT, 32'h00a);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, rls_pkg::OFS_SERIAL, 32'h0001 | (i << 8));
            cyc(2);
            chk(baud_div, divs[i]);
        end
        bus(1'b1, rls_pkg::OFS_SERIAL, 32'h0301);
        bus(1'b1, rls_pkg::OFS_WAIT, 32'h003);
        bus(1'b1, rls_pkg::OFS_OUTFN, 32'h0b0b);
        bus(1'b1, rls_pkg::OFS_VMIN, 32'h064);
        bus(1'b1, rls_pkg::OFS_CMIN, 32'h064);
        $display("reset and config done");
    endtask
    // wait is 3 tenths: nothing at 20 cycles, action well before 60
    task automatic loss_case(input logic [31:0] ctl, input logic [9:0] v, input logic [9:0] c,
                             input logic e);
        bus(1'b1, rls_pkg::OFS_CTRL, ctl);
        v_in <= v;
        c_in <= c;
        cyc(20);
        chk(relay, 1'b0);
        @(posedge ref_clk);
        freq_ref_in <= 16'h0bad;
        cyc(40);
        chk(relay, e);
        chk(oe_n, !e);
        chk(od_out, 1'b0);
        chk(cut, e && ctl[3:2] == 2'h1);
        chk(decel, e && ctl[3:2] == 2'h2);
        chk(freq_cmd, e ? 16'h1234 : 16'h0bad);
        @(posedge ref_clk);
        v_in <= 10'h1f4;
        c_in <= 10'h1f4;
        freq_ref_in <= 16'h1234;
        cyc(5);
        $display("loss case %h done", ctl);
    endtask
    task automatic t_dropout;
        bus(1'b1, rls_pkg::OFS_CTRL, 32'h36);
        v_in <= 10'h03c;
        cyc(20);
        @(posedge ref_clk);
        v_in <= 10'h1f4;
        cyc(3);
        @(posedge ref_clk);
        v_in <= 10'h03c;
        // short of a full wait, but past where a kept count would act
        cyc(15);
        chk(relay, 1'b0);
        @(posedge ref_clk);
        v_in <= 10'h1f4;
        cyc(5);
        $display("dropout done");
    endtask
    task automatic t_serial;
        bus(1'b1, rls_pkg::OFS_CTRL, 32'h0370);
        rd(rls_pkg::OFS_CTRL, 32'h0370);
        plc.send_frame(8'h01, rls_pkg::FC_READ_HOLD, g);
        chk(g, 1'b1);
        plc.send_frame(8'h01, 8'h01, g);
        chk(g, 1'b0);
        plc.send_frame(8'h02, rls_pkg::FC_WRITE_ONE, g);
        chk(g, 1'b0);
        chk(stop_bits, 2'h2);
        bus(1'b1, rls_pkg::OFS_CTRL, 32'h1370);
        plc.send_frame(8'h01, 8'h01, g);
        chk(g, 1'b1);
        chk(stop_bits, 2'h1);
        tx_request <= 1'b1;
        cyc(5);
        chk(line_drive_en, 1'b1);
        bus(1'b1, rls_pkg::OFS_COMM_TO, 32'h002);
        tx_request <= 1'b0;
        cyc(60);
        rd(rls_pkg::OFS_STATUS, 32'h4);
        bus(1'b1, rls_pkg::OFS_SERIAL, 32'h1301);
        cyc(80);
        chk(relay, 1'b1);
        plc.send_frame(8'h01, 8'h01, g);
        cyc(3);
        chk(relay, 1'b0);
        $display("serial done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        loss_case(32'h34, 10'h03c, 10'h1f4, 1'b0);
        loss_case(32'h35, 10'h03c, 10'h1f4, 1'b0);
        loss_case(32'h31, 10'h028, 10'h1f4, 1'b1);
        loss_case(32'h3a, 10'h03c, 10'h1f4, 1'b1);
        loss_case(32'h66, 10'h1f4, 10'h05a, 1'b1);
        loss_case(32'h5a, 10'h000, 10'h1f4, 1'b0);
        t_dropout;
        t_serial;
        finish_test;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        finish_test;
    end
endmodule // rls_supervisor_test

// ==== src/rls_pkg.sv ====
package rls_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TENTH_SEC_NS = 100000000;
    localparam int TENTH_SEC_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;
    localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_WAIT = 6'h04;
    localparam logic [5:0] OFS_OUTFN = 6'h08;
    localparam logic [5:0] OFS_SERIAL = 6'h0c;
    localparam logic [5:0] OFS_COMM_TO = 6'h10;
    localparam logic [5:0] OFS_VMIN = 6'h14;
    localparam logic [5:0] OFS_CMIN = 6'h18;
    localparam logic [5:0] OFS_STATUS = 6'h1c;
    localparam logic [5:0] OFS_FREQ = 6'h20;
    // field positions
    localparam int CTRL_CRIT_LSB = 0;
    localparam int CTRL_ACT_LSB = 2;
    localparam int CTRL_FSRC_LSB = 4;
    localparam int CTRL_RSRC_LSB = 8;
    localparam int CTRL_PROT_BIT = 12;
    localparam int OUTFN_RELAY_LSB = 8;
    localparam int SER_BAUD_LSB = 8;
    localparam int SER_LOST_LSB = 12;
    // reset values, limits and the loss function code
    localparam logic [1:0] CRIT_RST = 2'h0;
    localparam logic [1:0] ACT_RST = 2'h0;
    localparam logic [3:0] FSRC_RST = 4'h0;
    localparam logic [3:0] RSRC_RST = 4'h0;
    localparam logic [10:0] WAIT_RST = 11'h00a;
    localparam logic [10:0] WAIT_MIN = 11'h001;
    localparam logic [10:0] WAIT_MAX = 11'h4b0;
    localparam logic [4:0] OD_FN_RST = 5'h0c;
    localparam logic [4:0] RELAY_FN_RST = 5'h11;
    localparam logic [4:0] FN_REF_LOSS = 5'h0b;
    localparam logic [7:0] STATION_RST = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hfa;
    localparam logic [2:0] BAUD_RST = 3'h3;
    localparam logic [2:0] BAUD_MAX = 3'h4;
    localparam logic [1:0] LOST_RST = 2'h0;
    localparam logic [10:0] COMM_TO_RST = 11'h00a;
    localparam logic [9:0] MIN_RST = 10'h000;
    // source and function codes, data width
    localparam logic [3:0] SRC_VOLT = 4'h3;
    localparam logic [3:0] SRC_VOLT_ALT = 4'h4;
    localparam logic [3:0] SRC_CUR = 4'h5;
    localparam logic [3:0] SRC_SUM = 4'h6;
    localparam logic [3:0] SRC_SERIAL = 4'h7;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [3:0] DATA_BITS = 4'h8;
    typedef enum logic [1:0] {
        ST_OK = 2'b00,
        ST_WAIT = 2'b01,
        ST_LOST = 2'b10
    } rls_state_type;
endpackage

// ==== src/rls_supervisor.sv ====
`timescale 1ns/1ps
// Functional notes
// - criterion zero: no analog loss check
// - criterion one: below half the minimum
// - criterion two: below the minimum
// - summed source: either input low means loss
// - supervise analog and serial references
// - act after wait time, 0.1-120 s
// - action: hold, free run, decelerate
// - output function 11 shows reference loss
// - station number 1 to 250, distinct
// - five bit rates, code 3 default
// - protocol 0 binary, 1 ascii
// - two stop bits binary, one ascii
// - lost mode 0 takes no action
// - comm timeout default one second
// - binary slave answers only read/write
module rls_supervisor #(
    parameter int TENTH_CYCLES = rls_pkg::TENTH_SEC_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [9:0] voltage_analog_input,
    input wire logic [9:0] current_analog_input,
    input wire logic [15:0] freq_ref_in,
    input wire logic serial_rx,
    input wire logic frame_valid,
    input wire logic [7:0] frame_station,
    input wire logic [7:0] frame_function,
    input wire logic tx_request,
    output logic reply_grant,
    output logic line_drive_en,
    output logic [15:0] baud_div,
    output logic [1:0] stop_bits,
    output logic [3:0] data_bits,
    output logic [15:0] freq_cmd,
    output logic output_cut,
    output logic decel_req,
    output logic open_drain_output_out,
    output logic open_drain_output_oe_n,
    output logic fault_relay_output
);
    ////////////////////////////////////////////////////////////////
    // configuration registers
    logic [1:0] crit_ff, nxt_crit;
    logic [1:0] act_ff, nxt_act;
    logic [3:0] fsrc_ff, nxt_fsrc;
    logic [3:0] rsrc_ff, nxt_rsrc;
    logic prot_ff, nxt_prot;
    logic [10:0] wait_ff, nxt_wait;
    logic [4:0] odfn_ff, nxt_odfn;
    logic [4:0] rlfn_ff, nxt_rlfn;
    logic [7:0] station_ff, nxt_station;
    logic [2:0] baud_ff, nxt_baud;
    logic [1:0] lost_ff, nxt_lost;
    logic [10:0] comm_to_ff, nxt_comm_to;
    logic [9:0] vmin_ff, nxt_vmin;
    logic [9:0] cmin_ff, nxt_cmin;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] status_word;
    logic wr_go;

    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign wr_go = avs_write && !ack_ff && avs_byteenable[0] && avs_byteenable[1];
    assign avs_readdata = rdata_ff;

    always_comb
    begin
        nxt_crit = crit_ff;
        nxt_act = act_ff;
        nxt_fsrc = fsrc_ff;
        nxt_rsrc = rsrc_ff;
        nxt_prot = prot_ff;
        nxt_wait = wait_ff;
        nxt_odfn = odfn_ff;
        nxt_rlfn = rlfn_ff;
        nxt_station = station_ff;
        nxt_baud = baud_ff;
        nxt_lost = lost_ff;
        nxt_comm_to = comm_to_ff;
        nxt_vmin = vmin_ff;
        nxt_cmin = cmin_ff;
        nxt_ack = (avs_read || avs_write) && !ack_ff;
        nxt_rdata = rdata_ff;
        if (wr_go)
        begin
            case (avs_address)
                rls_pkg::OFS_CTRL:
                begin
                    // out-of-range criterion and action codes are refused, field keeps its value
                    if (avs_writedata[rls_pkg::CTRL_CRIT_LSB +: 2] != 2'h3)
                        nxt_crit = avs_writedata[rls_pkg::CTRL_CRIT_LSB +: 2];
                    if (avs_writedata[rls_pkg::CTRL_ACT_LSB +: 2] != 2'h3)
                        nxt_act = avs_writedata[rls_pkg::CTRL_ACT_LSB +: 2];
                    nxt_fsrc = avs_writedata[rls_pkg::CTRL_FSRC_LSB +: 4];
                    nxt_rsrc = avs_writedata[rls_pkg::CTRL_RSRC_LSB +: 4];
                    nxt_prot = avs_writedata[rls_pkg::CTRL_PROT_BIT];
                end
                rls_pkg::OFS_WAIT:
                    if (avs_writedata[10:0] >= rls_pkg::WAIT_MIN
                        && avs_writedata[10:0] <= rls_pkg::WAIT_MAX)
                        nxt_wait = avs_writedata[10:0];
                rls_pkg::OFS_OUTFN:
                begin
                    nxt_odfn = avs_writedata[4:0];
                    nxt_rlfn = avs_writedata[rls_pkg::OUTFN_RELAY_LSB +: 5];
                end
                rls_pkg::OFS_SERIAL:
                begin
                    if (avs_writedata[7:0] != 8'h00
                        && avs_writedata[7:0] <= rls_pkg::STATION_MAX)
                        nxt_station = avs_writedata[7:0];
                    if (avs_writedata[rls_pkg::SER_BAUD_LSB +: 3] <= rls_pkg::BAUD_MAX)
                        nxt_baud = avs_writedata[rls_pkg::SER_BAUD_LSB +: 3];
                    nxt_lost = avs_writedata[rls_pkg::SER_LOST_LSB +: 2];
                end
                rls_pkg::OFS_COMM_TO:
                    if (avs_writedata[10:0] != 11'h000)
                        nxt_comm_to = avs_writedata[10:0];
                rls_pkg::OFS_VMIN:
                    nxt_vmin = avs_writedata[9:0];
                rls_pkg::OFS_CMIN:
                    nxt_cmin = avs_writedata[9:0];
                default:
                    nxt_ack = 1'b1;
            endcase
        end
        if (avs_read && !ack_ff)
        begin
            case (avs_address)
                rls_pkg::OFS_CTRL:
                    nxt_rdata = {19'h00000, prot_ff, rsrc_ff, fsrc_ff, act_ff, crit_ff};
                rls_pkg::OFS_WAIT:
                    nxt_rdata = {21'h000000, wait_ff};
                rls_pkg::OFS_OUTFN:
                    nxt_rdata = {19'h00000, rlfn_ff, 3'h0, odfn_ff};
                rls_pkg::OFS_SERIAL:
                    nxt_rdata = {18'h00000, lost_ff, 1'b0, baud_ff, station_ff};
                rls_pkg::OFS_COMM_TO:
                    nxt_rdata = {21'h000000, comm_to_ff};
                rls_pkg::OFS_VMIN:
                    nxt_rdata = {22'h000000, vmin_ff};
                rls_pkg::OFS_CMIN:
                    nxt_rdata = {22'h000000, cmin_ff};
                rls_pkg::OFS_STATUS:
                    nxt_rdata = status_word;
                rls_pkg::OFS_FREQ:
                    nxt_rdata = {16'h0000, freq_cmd};
                default:
                    nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            crit_ff <= rls_pkg::CRIT_RST;
            act_ff <= rls_pkg::ACT_RST;
            fsrc_ff <= rls_pkg::FSRC_RST;
            rsrc_ff <= rls_pkg::RSRC_RST;
            prot_ff <= 1'b0;
            wait_ff <= rls_pkg::WAIT_RST;
            odfn_ff <= rls_pkg::OD_FN_RST;
            rlfn_ff <= rls_pkg::RELAY_FN_RST;
            station_ff <= rls_pkg::STATION_RST;
            baud_ff <= rls_pkg::BAUD_RST;
            lost_ff <= rls_pkg::LOST_RST;
            comm_to_ff <= rls_pkg::COMM_TO_RST;
            vmin_ff <= rls_pkg::MIN_RST;
            cmin_ff <= rls_pkg::MIN_RST;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            crit_ff <= nxt_crit;
            act_ff <= nxt_act;
            fsrc_ff <= nxt_fsrc;
            rsrc_ff <= nxt_rsrc;
            prot_ff <= nxt_prot;
            wait_ff <= nxt_wait;
            odfn_ff <= nxt_odfn;
            rlfn_ff <= nxt_rlfn;
            station_ff <= nxt_station;
            baud_ff <= nxt_baud;
            lost_ff <= nxt_lost;
            comm_to_ff <= nxt_comm_to;
            vmin_ff <= nxt_vmin;
            cmin_ff <= nxt_cmin;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // serial line: sync, activity, framing settings
    logic rx_s1_ff, rx_s2_ff, rx_s3_ff;
    logic rx_edge;
    logic [19:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick;
    logic comm_expired;
    logic grant_ff, nxt_grant;
    logic [15:0] div_ff, nxt_div;

    // the edge detector reads stage two and three only
    assign rx_edge = rx_s2_ff ^ rx_s3_ff;
    assign tick = (tick_cnt_ff == 20'(TENTH_CYCLES - 1));
    assign nxt_tick_cnt = tick ? 20'h00000 : tick_cnt_ff + 20'h00001;

    always_comb
    begin
        case (baud_ff)
            3'h0: nxt_div = 16'(rls_pkg::CLK_HZ / 1200);
            3'h1: nxt_div = 16'(rls_pkg::CLK_HZ / 2400);
            3'h2: nxt_div = 16'(rls_pkg::CLK_HZ / 4800);
            3'h3: nxt_div = 16'(rls_pkg::CLK_HZ / 9600);
            default: nxt_div = 16'(rls_pkg::CLK_HZ / 19200);
        endcase
        // a request for this station is answered; in binary only with a read or write code
        nxt_grant = frame_valid && frame_station == station_ff
            && (prot_ff || frame_function == rls_pkg::FC_READ_HOLD
            || frame_function == rls_pkg::FC_READ_INPUT
            || frame_function == rls_pkg::FC_WRITE_ONE
            || frame_function == rls_pkg::FC_WRITE_MANY);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_s3_ff <= 1'b1;
            tick_cnt_ff <= 20'h00000;
            grant_ff <= 1'b0;
            div_ff <= 16'h0000;
        end
        else
        begin
            rx_s1_ff <= serial_rx;
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
            tick_cnt_ff <= nxt_tick_cnt;
            grant_ff <= nxt_grant;
            div_ff <= nxt_div;
        end
    end

    assign reply_grant = grant_ff;
    assign baud_div = div_ff;
    assign stop_bits = prot_ff ? 2'h1 : 2'h2;
    assign data_bits = rls_pkg::DATA_BITS;
    // no drive while the synced line is low or has just toggled: half duplex
    assign line_drive_en = tx_request && rx_s2_ff && !rx_edge;

    rls_timer u_comm_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .restart(rx_edge),
        .tick(tick),
        .limit(comm_to_ff),
        .expired(comm_expired)
    );

    ////////////////////////////////////////////////////////////////
    // loss detection and action
    logic v_low, c_low, raw_loss;
    logic [9:0] v_thr, c_thr;
    logic loss_expired;
    rls_pkg::rls_state_type state_ff, nxt_state;
    logic [15:0] freq_ff, nxt_freq;
    logic cut_ff, nxt_cut;
    logic decel_ff, nxt_decel;
    logic lost_flag;

    assign v_thr = (crit_ff == 2'h1) ? {1'b0, vmin_ff[9:1]} : vmin_ff;
    assign c_thr = (crit_ff == 2'h1) ? {1'b0, cmin_ff[9:1]} : cmin_ff;
    assign v_low = voltage_analog_input < v_thr;
    assign c_low = current_analog_input < c_thr;

    always_comb
    begin
        raw_loss = 1'b0;
        if (crit_ff != 2'h0)
        begin
            case (fsrc_ff)
                rls_pkg::SRC_VOLT, rls_pkg::SRC_VOLT_ALT: raw_loss = v_low;
                rls_pkg::SRC_CUR: raw_loss = c_low;
                rls_pkg::SRC_SUM: raw_loss = v_low || c_low;
                default: raw_loss = 1'b0;
            endcase
        end
        // lost mode 0 leaves a silent link without consequence
        if (fsrc_ff == rls_pkg::SRC_SERIAL && lost_ff != 2'h0 && comm_expired)
            raw_loss = 1'b1;
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_freq = freq_ff;
        case (state_ff)
            rls_pkg::ST_OK:
            begin
                nxt_freq = freq_ref_in;
                if (raw_loss)
                    nxt_state = rls_pkg::ST_WAIT;
            end
            rls_pkg::ST_WAIT:
                if (!raw_loss)
                    nxt_state = rls_pkg::ST_OK;
                else if (loss_expired)
                    nxt_state = rls_pkg::ST_LOST;
            rls_pkg::ST_LOST:
                if (!raw_loss)
                    nxt_state = rls_pkg::ST_OK;
            default:
                nxt_state = rls_pkg::ST_OK;
        endcase
        // action follows the selection live while lost
        nxt_cut = nxt_state == rls_pkg::ST_LOST && act_ff == 2'h1;
        nxt_decel = nxt_state == rls_pkg::ST_LOST && act_ff == 2'h2;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= rls_pkg::ST_OK;
            freq_ff <= 16'h0000;
            cut_ff <= 1'b0;
            decel_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            freq_ff <= nxt_freq;
            cut_ff <= nxt_cut;
            decel_ff <= nxt_decel;
        end
    end

    rls_timer u_loss_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .restart(state_ff != rls_pkg::ST_WAIT),
        .tick(tick),
        .limit(wait_ff),
        .expired(loss_expired)
    );

    assign lost_flag = state_ff == rls_pkg::ST_LOST;
    assign freq_cmd = freq_ff;
    assign output_cut = cut_ff;
    assign decel_req = decel_ff;
    assign open_drain_output_out = 1'b0;
    assign open_drain_output_oe_n = !(lost_flag && odfn_ff == rls_pkg::FN_REF_LOSS);
    assign fault_relay_output = lost_flag && rlfn_ff == rls_pkg::FN_REF_LOSS;
    assign status_word = {25'h0000000, fault_relay_output, !open_drain_output_oe_n,
        decel_ff, cut_ff, comm_expired, lost_flag, raw_loss};

    ////////////////////////////////////////////////////////////////
    // checks
    AST_CRIT_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        crit_ff == 2'h0 && fsrc_ff != rls_pkg::SRC_SERIAL |-> !raw_loss)
        else $error("loss seen with detection off");
    AST_HALF_MIN: assert property (@(posedge ref_clk) disable iff (rst)
        crit_ff == 2'h1 && fsrc_ff == rls_pkg::SRC_VOLT
        && voltage_analog_input < {1'b0, vmin_ff[9:1]} |-> raw_loss)
        else $error("half-minimum loss missed");
    AST_BELOW_MIN: assert property (@(posedge ref_clk) disable iff (rst)
        crit_ff == 2'h2 && fsrc_ff == rls_pkg::SRC_CUR
        |-> raw_loss == (current_analog_input < cmin_ff))
        else $error("minimum loss mismatch");
    AST_SUM_EITHER: assert property (@(posedge ref_clk) disable iff (rst)
        crit_ff == 2'h2 && fsrc_ff == rls_pkg::SRC_SUM
        && (voltage_analog_input < vmin_ff || current_analog_input < cmin_ff) |-> raw_loss)
        else $error("summed source loss missed");
    AST_COMM_LOSS: assert property (@(posedge ref_clk) disable iff (rst)
        fsrc_ff == rls_pkg::SRC_SERIAL && comm_expired && lost_ff != 2'h0 |-> raw_loss)
        else $error("serial loss missed");
    AST_WAIT_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(lost_flag) |-> $past(loss_expired) && $past(state_ff) == rls_pkg::ST_WAIT)
        else $error("acted before wait time");
    AST_FREE_RUN: assert property (@(posedge ref_clk) disable iff (rst)
        lost_flag && act_ff == 2'h1 && $stable(act_ff) |-> output_cut && !decel_req)
        else $error("free run not applied");
    AST_HOLD_FREQ: assert property (@(posedge ref_clk) disable iff (rst)
        state_ff != rls_pkg::ST_OK ##1 state_ff != rls_pkg::ST_OK |-> $stable(freq_cmd))
        else $error("frequency moved during loss");
    AST_FLAG_OUT: assert property (@(posedge ref_clk) disable iff (rst)
        rlfn_ff == rls_pkg::FN_REF_LOSS |-> fault_relay_output == lost_flag)
        else $error("relay flag wrong");
    AST_STATION: assert property (@(posedge ref_clk) disable iff (rst)
        station_ff != 8'h00 && station_ff <= rls_pkg::STATION_MAX)
        else $error("station out of range");
    AST_STOP_BITS: assert property (@(posedge ref_clk) disable iff (rst)
        stop_bits == (prot_ff ? 2'h1 : 2'h2))
        else $error("stop bits wrong");
    AST_DROPOUT: assert property (@(posedge ref_clk) disable iff (rst)
        state_ff == rls_pkg::ST_WAIT && !raw_loss |=> state_ff == rls_pkg::ST_OK ##1 !lost_flag)
        else $error("dropout not forgiven");
    AST_BUS_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    COV_LOST: cover property (@(posedge ref_clk) disable iff (rst) $rose(lost_flag));
    COV_DROPOUT: cover property (@(posedge ref_clk) disable iff (rst)
        state_ff == rls_pkg::ST_WAIT ##1 state_ff == rls_pkg::ST_OK);
    COV_DECEL: cover property (@(posedge ref_clk) disable iff (rst) $rose(decel_req));
endmodule // rls_supervisor

// ==== src/rls_timer.sv ====
`timescale 1ns/1ps
// counts tenth-second ticks; expired holds until restart
module rls_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic tick,
    input wire logic [10:0] limit,
    output logic expired
);
    logic [10:0] cnt_ff;
    logic [10:0] nxt_cnt;
    logic exp_ff;
    logic nxt_exp;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_exp = exp_ff;
        if (restart)
        begin
            nxt_cnt = 11'h000;
            nxt_exp = 1'b0;
        end
        else if (tick && !exp_ff)
        begin
            nxt_cnt = cnt_ff + 11'h001;
            if (nxt_cnt >= limit)
                nxt_exp = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= 11'h000;
            exp_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            exp_ff <= nxt_exp;
        end
    end

    assign expired = exp_ff;
endmodule // rls_timer
